// ---- logic/lockin_pkg.sv ----
// Constants and types shared by the lock-in setting command store
`default_nettype none
package lockin_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_KIND    = 8'h00;
    localparam logic [7:0] OFS_QUAL    = 8'h04;
    localparam logic [7:0] OFS_FREQ    = 8'h08;
    localparam logic [7:0] OFS_FTRIM   = 8'h0C;
    localparam logic [7:0] OFS_NOTCH   = 8'h10;
    localparam logic [7:0] OFS_FULL_SCALE_SENSITIVITY    = 8'h14;
    localparam logic [7:0] OFS_RESV    = 8'h18;
    localparam logic [7:0] OFS_TC      = 8'h1C;
    localparam logic [7:0] OFS_ROLL    = 8'h20;
    localparam logic [7:0] OFS_FUNC    = 8'h24;
    localparam logic [7:0] OFS_OUTPUT_OFFSET_ENABLE    = 8'h28;
    localparam logic [7:0] OFS_OUTPUT_OFFSET_AMOUNT    = 8'h2C;
    localparam logic [7:0] OFS_CLICK   = 8'h30;
    localparam logic [7:0] OFS_ALARM   = 8'h34;
    localparam logic [7:0] OFS_SAVE    = 8'h38;
    localparam logic [7:0] OFS_RECALL  = 8'h3C;
    localparam logic [7:0] OFS_CYC0    = 8'h40;
    localparam logic [7:0] OFS_TOKEN   = 8'h4C;
    localparam logic [7:0] OFS_CYC_STEP = 8'h04;

    // ---------------------------------------------------------------
    // Automatic cycles: gain, phase, offset
    // ---------------------------------------------------------------
    localparam int CYC_N     = 3;
    localparam int CH_OFFSET = 2;

    typedef enum logic [2:0] {
        CYC_IDLE     = 3'h0,
        CYC_RUN      = 3'h1,
        CYC_CYCLE_CANNOT_START = 3'h2,
        CYC_SUCCESS  = 3'h3,
        CYC_FAILED   = 3'h4
    } cycle_state_e;

    // ---------------------------------------------------------------
    // Limits (frequency in 0.01 Hz, offset in 0.01 percent)
    // ---------------------------------------------------------------
    localparam logic [31:0] KIND_MAX    = 32'h0000_0004;
    localparam logic [31:0] QUAL_MAX    = 32'h0000_0006;
    localparam logic [31:0] FULL_SCALE_SENSITIVITY_MAX    = 32'h0000_0014;
    localparam logic [31:0] RESV_MAX    = 32'h0000_0002;
    localparam logic [31:0] TC_MAX      = 32'h0000_000C;
    localparam logic [31:0] BIT_MAX     = 32'h0000_0001;
    localparam logic [31:0] BLOCK_MAX   = 32'h0000_0008;
    localparam logic [31:0] BLOCK_DEF   = 32'h0000_0009;
    localparam logic [31:0] FREQ_MIN    = 32'h0000_00C8;
    localparam logic [31:0] FREQ_MAX    = 32'h00A7_D8C0;
    localparam logic signed [31:0] TRIM_LIM = 32'sh0000_03E7;
    localparam logic signed [31:0] OUTPUT_OFFSET_AMOUNT_LIM = 32'sh0001_86A0;

    // ---------------------------------------------------------------
    // Setting word and reset values
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0]         kind;
        logic [2:0]         qual;
        logic [23:0]        freq;
        logic signed [10:0] ftrim;
        logic signed [10:0] notch;
        logic [4:0]         full_scale_sensitivity;
        logic [1:0]         resv;
        logic [3:0]         tc;
        logic               roll;
        logic               func;
        logic               output_offset_enable;
        logic signed [17:0] output_offset_amount;
        logic               click;
        logic               alarm;
    } settings_s;

    localparam int SET_W = $bits(settings_s);

    localparam settings_s SET_DEFAULT = '{
        kind:  3'h4,
        qual:  3'h0,
        freq:  24'h01_86A0,
        ftrim: 11'sh000,
        notch: 11'sh000,
        full_scale_sensitivity:  5'h14,
        resv:  2'h2,
        tc:    4'h5,
        roll:  1'b0,
        func:  1'b0,
        output_offset_enable:  1'b0,
        output_offset_amount:  18'sh0_0000,
        click: 1'b1,
        alarm: 1'b1
    };

endpackage
`default_nettype wire

// ---- logic/settings_block_mem.sv ----
// Storage for the nine saved setting blocks
`timescale 1ns/1ps
`default_nettype none
module settings_block_mem (
    input  wire logic                         clk_i,
    input  wire logic                         wr_en_i,
    input  wire logic                         rd_en_i,
    input  wire logic [3:0]                   addr_i,
    input  wire logic [lockin_pkg::SET_W-1:0] wr_data_i,
    output logic      [lockin_pkg::SET_W-1:0] rd_data_o
);
    import lockin_pkg::*;

    logic [SET_W-1:0] mem_r [0:8];

    always_ff @(posedge clk_i) begin
        if (wr_en_i && addr_i <= 4'h8) begin
            mem_r[addr_i] <= wr_data_i;
        end
        if (rd_en_i && addr_i <= 4'h8) begin
            rd_data_o <= mem_r[addr_i];
        end
    end

endmodule
`default_nettype wire

// ---- logic/setting_command_store.sv ----
// Remote setting store for input filter, gain, output and automatic cycles
// Operation
// R1: Hold input filter kind code 0..4 and report it on read.
// R2: Hold filter quality code 0..6, Q of 1 to 100.
// R3: Centre frequency settable 2.0 to 110000.0 Hz, default 1000.00 Hz.
// R4: Frequency trim signed -999..+999, default 0.
// R5: Notch depth trim signed -999..+999, default 0, readable.
// R6: Sensitivity codes 0..20, 100 nV to 500 mV in 1-2-5 steps.
// R7: Dynamic reserve code: 0 high, 1 normal, 2 low noise.
// R8: Time constant codes 0..12, minimum then 1 ms to 300 s.
// R9: Rolloff code 0 for 6 dB, 1 for 12 dB per octave.
// R10: Output function code 0 lock-in, 1 AC voltmeter.
// R11: Output offset enable flag, 0 off, 1 on.
// R12: Offset amount in percent full scale, -1000..+1000, default 0.
// R13: Key click enable bit, reachable only over the remote port.
// R14: Alarm sound enable bit, all other sounds, remote only.
// R15: Save copies settings to block 0..8; read returns last saved.
// R16: Recall loads block 0..8 or defaults for 9; read returns last.
// R17: Gain cycle: 1 starts, 0 cancels one in progress.
// R18: Cycle status reads 0 idle,1 running,2 cannot start,3 done,4 failed.
// R19: Phase cycle: 1 starts, 0 cancels, same five states.
// R20: Offset cycle: 1 starts, 0 cancels, same five states.
// R21: Offset cycle runs regardless of enable and writes the nulling offset.
// R22: Coded reads give the code; token format bit selects text outside.
// R23: Reset loads flat, Q1, 500 mV, low noise, 100 ms, 6 dB, defaults.
// R24: Out-of-range set values are rejected, setting left unchanged.
`timescale 1ns/1ps
`default_nettype none
module setting_command_store (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic [7:0]                  adr_i,
    input  wire logic [31:0]                 dat_i,
    output logic      [31:0]                 dat_o,
    input  wire logic                        we_i,
    input  wire logic [3:0]                  sel_i,
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    output logic                             ack_o,
    input  wire logic [lockin_pkg::CYC_N-1:0] cycle_ready_i,
    input  wire logic [lockin_pkg::CYC_N-1:0] cycle_done_i,
    input  wire logic [lockin_pkg::CYC_N-1:0] cycle_fail_i,
    input  wire logic signed [17:0]          offset_null_i,
    output logic      [lockin_pkg::CYC_N-1:0] cycle_run_o,
    output logic      [2:0]                  input_filter_kind_o,
    output logic      [2:0]                  input_filter_quality_o,
    output logic      [23:0]                 input_filter_centre_freq_o,
    output logic signed [10:0]               input_filter_freq_trim_o,
    output logic signed [10:0]               notch_depth_trim_o,
    output logic      [4:0]                  full_scale_sensitivity_o,
    output logic      [1:0]                  dynamic_reserve_select_o,
    output logic      [3:0]                  output_time_constant_o,
    output logic                             output_rolloff_o,
    output logic                             output_function_select_o,
    output logic                             output_offset_enable_o,
    output logic signed [17:0]               output_offset_amount_o,
    output logic                             key_click_sound_enable_o,
    output logic                             alarm_sound_enable_o,
    output logic                             token_reply_format_o
);
    import lockin_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        settings_s             set;
        logic [3:0]            saved;
        logic [3:0]            recalled;
        logic                  token;
        logic [CYC_N-1:0][2:0] cst;
        logic [CYC_N-1:0]      run;
        logic                  ack;
        logic [31:0]           dat;
        logic                  rec_pend;
    } state_s;

    localparam state_s STATE_RESET = '{
        set:      SET_DEFAULT,
        saved:    4'h0,
        recalled: 4'h9,
        token:    1'b0,
        cst:      '0,
        run:      '0,
        ack:      1'b0,
        dat:      32'h0000_0000,
        rec_pend: 1'b0
    };

    state_s           q_r;
    state_s           q_nxt;
    logic             mem_we;
    logic             mem_re;
    logic [3:0]       mem_addr;
    logic [SET_W-1:0] mem_rd;
    logic             wr_go;
    logic signed [31:0] wd_s;

    settings_block_mem u_mem (
        .clk_i     (clk_i),
        .wr_en_i   (mem_we),
        .rd_en_i   (mem_re),
        .addr_i    (mem_addr),
        .wr_data_i (q_r.set),
        .rd_data_o (mem_rd)
    );

    // ---------------------------------------------------------------
    // Read multiplexer
    // ---------------------------------------------------------------
    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == OFS_KIND) begin
            r = {29'h0, q_r.set.kind};                             // R1 R22
        end else if (a == OFS_QUAL) begin
            r = {29'h0, q_r.set.qual};
        end else if (a == OFS_FREQ) begin
            r = {8'h00, q_r.set.freq};
        end else if (a == OFS_FTRIM) begin
            r = {{21{q_r.set.ftrim[10]}}, q_r.set.ftrim};
        end else if (a == OFS_NOTCH) begin
            r = {{21{q_r.set.notch[10]}}, q_r.set.notch};          // R5
        end else if (a == OFS_FULL_SCALE_SENSITIVITY) begin
            r = {27'h0, q_r.set.full_scale_sensitivity};
        end else if (a == OFS_RESV) begin
            r = {30'h0, q_r.set.resv};
        end else if (a == OFS_TC) begin
            r = {28'h0, q_r.set.tc};
        end else if (a == OFS_ROLL) begin
            r = {31'h0, q_r.set.roll};
        end else if (a == OFS_FUNC) begin
            r = {31'h0, q_r.set.func};
        end else if (a == OFS_OUTPUT_OFFSET_ENABLE) begin
            r = {31'h0, q_r.set.output_offset_enable};
        end else if (a == OFS_OUTPUT_OFFSET_AMOUNT) begin
            r = {{14{q_r.set.output_offset_amount[17]}}, q_r.set.output_offset_amount};
        end else if (a == OFS_CLICK) begin
            r = {31'h0, q_r.set.click};
        end else if (a == OFS_ALARM) begin
            r = {31'h0, q_r.set.alarm};
        end else if (a == OFS_SAVE) begin
            r = {28'h0, q_r.saved};                                // R15
        end else if (a == OFS_RECALL) begin
            r = {28'h0, q_r.recalled};                             // R16
        end else if (a == OFS_CYC0) begin
            r = {29'h0, q_r.cst[0]};                               // R18
        end else if (a == OFS_CYC0 + OFS_CYC_STEP) begin
            r = {29'h0, q_r.cst[1]};
        end else if (a == OFS_CYC0 + OFS_CYC_STEP + OFS_CYC_STEP) begin
            r = {29'h0, q_r.cst[2]};
        end else if (a == OFS_TOKEN) begin
            r = {31'h0, q_r.token};
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    assign wd_s  = $signed(dat_i);
    assign wr_go = cyc_i && stb_i && we_i && q_r.ack && (sel_i == 4'hF);

    always_comb begin
        q_nxt    = q_r;
        mem_we   = 1'b0;
        mem_re   = 1'b0;
        mem_addr = dat_i[3:0];
        q_nxt.ack      = cyc_i && stb_i && !q_r.ack;
        q_nxt.dat      = 32'h0000_0000;
        q_nxt.rec_pend = 1'b0;
        if (q_nxt.ack && !we_i) begin
            q_nxt.dat = read_word(adr_i);
        end
        // Writes land on the edge where the master sees ack
        if (wr_go) begin
            if (adr_i == OFS_KIND) begin
                if (dat_i <= KIND_MAX) q_nxt.set.kind = dat_i[2:0];     // R1 R24
            end else if (adr_i == OFS_QUAL) begin
                if (dat_i <= QUAL_MAX) q_nxt.set.qual = dat_i[2:0];     // R2 R24
            end else if (adr_i == OFS_FREQ) begin
                if (dat_i >= FREQ_MIN && dat_i <= FREQ_MAX) begin
                    q_nxt.set.freq = dat_i[23:0];                       // R3 R24
                end
            end else if (adr_i == OFS_FTRIM) begin
                if (wd_s >= -TRIM_LIM && wd_s <= TRIM_LIM) begin
                    q_nxt.set.ftrim = wd_s[10:0];                       // R4
                end
            end else if (adr_i == OFS_NOTCH) begin
                if (wd_s >= -TRIM_LIM && wd_s <= TRIM_LIM) begin
                    q_nxt.set.notch = wd_s[10:0];                       // R5
                end
            end else if (adr_i == OFS_FULL_SCALE_SENSITIVITY) begin
                if (dat_i <= FULL_SCALE_SENSITIVITY_MAX) q_nxt.set.full_scale_sensitivity = dat_i[4:0];     // R6
            end else if (adr_i == OFS_RESV) begin
                if (dat_i <= RESV_MAX) q_nxt.set.resv = dat_i[1:0];     // R7
            end else if (adr_i == OFS_TC) begin
                if (dat_i <= TC_MAX) q_nxt.set.tc = dat_i[3:0];         // R8
            end else if (adr_i == OFS_ROLL) begin
                if (dat_i <= BIT_MAX) q_nxt.set.roll = dat_i[0];        // R9
            end else if (adr_i == OFS_FUNC) begin
                if (dat_i <= BIT_MAX) q_nxt.set.func = dat_i[0];        // R10
            end else if (adr_i == OFS_OUTPUT_OFFSET_ENABLE) begin
                if (dat_i <= BIT_MAX) q_nxt.set.output_offset_enable = dat_i[0];        // R11
            end else if (adr_i == OFS_OUTPUT_OFFSET_AMOUNT) begin
                if (wd_s >= -OUTPUT_OFFSET_AMOUNT_LIM && wd_s <= OUTPUT_OFFSET_AMOUNT_LIM) begin
                    q_nxt.set.output_offset_amount = wd_s[17:0];                        // R12
                end
            end else if (adr_i == OFS_CLICK) begin
                if (dat_i <= BIT_MAX) q_nxt.set.click = dat_i[0];       // R13
            end else if (adr_i == OFS_ALARM) begin
                if (dat_i <= BIT_MAX) q_nxt.set.alarm = dat_i[0];       // R14
            end else if (adr_i == OFS_SAVE) begin
                if (dat_i <= BLOCK_MAX) begin
                    mem_we      = 1'b1;                                 // R15
                    q_nxt.saved = dat_i[3:0];
                end
            end else if (adr_i == OFS_RECALL) begin
                if (dat_i == BLOCK_DEF) begin
                    q_nxt.set      = SET_DEFAULT;                       // R16
                    q_nxt.recalled = dat_i[3:0];
                end else if (dat_i <= BLOCK_MAX) begin
                    mem_re         = 1'b1;                              // R16
                    q_nxt.rec_pend = 1'b1;
                    q_nxt.recalled = dat_i[3:0];
                end
            end else if (adr_i == OFS_TOKEN) begin
                if (dat_i <= BIT_MAX) q_nxt.token = dat_i[0];           // R22
            end
        end
        if (q_r.rec_pend) begin
            q_nxt.set = mem_rd;
        end
        // Automatic cycles; hardware completion overrides a same-cycle cancel
        for (int ch = 0; ch < CYC_N; ch++) begin
            if (wr_go && adr_i == OFS_CYC0 + 8'(ch) * OFS_CYC_STEP) begin
                if (dat_i == 32'h0000_0001) begin
                    if (q_r.run[ch]) begin
                        q_nxt.cst[ch] = CYC_RUN;
                    end else if (cycle_ready_i[ch]) begin
                        q_nxt.cst[ch] = CYC_RUN;                        // R17 R19 R20
                        q_nxt.run[ch] = 1'b1;
                    end else begin
                        q_nxt.cst[ch] = CYC_CYCLE_CANNOT_START;                   // R18
                    end
                end else if (dat_i == 32'h0000_0000 && q_r.run[ch]) begin
                    q_nxt.cst[ch] = CYC_IDLE;                           // R17 R19 R20
                    q_nxt.run[ch] = 1'b0;
                end
            end
            if (q_r.run[ch] && cycle_done_i[ch]) begin
                q_nxt.cst[ch] = CYC_SUCCESS;                            // R18
                q_nxt.run[ch] = 1'b0;
                if (ch == CH_OFFSET) begin
                    if (32'(offset_null_i) >= -OUTPUT_OFFSET_AMOUNT_LIM && 32'(offset_null_i) <= OUTPUT_OFFSET_AMOUNT_LIM) begin
                        q_nxt.set.output_offset_amount = offset_null_i;                 // R21
                    end else begin
                        q_nxt.cst[ch] = CYC_FAILED;
                    end
                end
            end else if (q_r.run[ch] && cycle_fail_i[ch]) begin
                q_nxt.cst[ch] = CYC_FAILED;                             // R18
                q_nxt.run[ch] = 1'b0;
            end
        end
        if (rst_i) begin
            q_nxt = STATE_RESET;                                        // R23
        end
    end

    always_ff @(posedge clk_i) begin
        q_r <= q_nxt;
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign ack_o                      = q_r.ack;
    assign dat_o                      = q_r.dat;
    assign cycle_run_o                = q_r.run;
    assign input_filter_kind_o        = q_r.set.kind;
    assign input_filter_quality_o     = q_r.set.qual;
    assign input_filter_centre_freq_o = q_r.set.freq;
    assign input_filter_freq_trim_o   = q_r.set.ftrim;
    assign notch_depth_trim_o         = q_r.set.notch;
    assign full_scale_sensitivity_o   = q_r.set.full_scale_sensitivity;
    assign dynamic_reserve_select_o   = q_r.set.resv;
    assign output_time_constant_o     = q_r.set.tc;
    assign output_rolloff_o           = q_r.set.roll;
    assign output_function_select_o   = q_r.set.func;
    assign output_offset_enable_o     = q_r.set.output_offset_enable;
    assign output_offset_amount_o     = q_r.set.output_offset_amount;
    assign key_click_sound_enable_o   = q_r.set.click;
    assign alarm_sound_enable_o       = q_r.set.alarm;
    assign token_reply_format_o       = q_r.token;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wr(logic [7:0] a);
        cyc_i && stb_i && we_i && ack_o && sel_i == 4'hF && adr_i == a;
    endsequence

    sequence s_start(int ch);
        s_wr(OFS_CYC0 + 8'(ch) * OFS_CYC_STEP)
            ##0 (dat_i == 32'h0000_0001 && !cycle_run_o[ch] && cycle_ready_i[ch]);
    endsequence

    chk_kind_range: assert property (input_filter_kind_o <= 3'h4) // R1
        else $error("filter kind code out of range");
    chk_quality_range: assert property (input_filter_quality_o <= 3'h6) // R2
        else $error("quality code out of range");
    chk_freq_range: assert property (input_filter_centre_freq_o >= 24'h00_00C8
        && input_filter_centre_freq_o <= 24'hA7_D8C0) // R3
        else $error("centre frequency out of range");
    chk_trim_range: assert property (input_filter_freq_trim_o <= 11'sh3E7
        && input_filter_freq_trim_o >= -11'sh3E7) // R4
        else $error("frequency trim out of range");
    chk_full_scale_sensitivity_range: assert property (full_scale_sensitivity_o <= 5'h14) // R6
        else $error("sensitivity code out of range");
    chk_tc_range: assert property (output_time_constant_o <= 4'hC) // R8
        else $error("time constant code out of range");
    chk_reject_keep: assert property (s_wr(OFS_KIND) ##0 dat_i > 32'h0000_0004
        |=> $stable(input_filter_kind_o)) // R24
        else $error("rejected kind write changed the setting");
    chk_gain_start: assert property (s_start(0) |=> cycle_run_o[0] && q_r.cst[0] == CYC_RUN) // R17
        else $error("gain cycle did not start");
    chk_phase_cancel: assert property (s_wr(OFS_CYC0 + OFS_CYC_STEP) ##0 dat_i == 32'h0000_0000
        && cycle_run_o[1] && !cycle_done_i[1] && !cycle_fail_i[1]
        |=> !cycle_run_o[1] && q_r.cst[1] == CYC_IDLE) // R19
        else $error("phase cycle not cancelled");
    chk_offset_null: assert property (cycle_run_o[CH_OFFSET] && cycle_done_i[CH_OFFSET]
        && offset_null_i <= 18'sh1_86A0 && offset_null_i >= -18'sh1_86A0
        |=> output_offset_amount_o == $past(offset_null_i) && q_r.cst[CH_OFFSET] == CYC_SUCCESS) // R21
        else $error("offset cycle did not write nulling value");
    chk_recall_default: assert property (s_wr(OFS_RECALL) ##0 dat_i == 32'h0000_0009
        |=> q_r.set == SET_DEFAULT ##1 !ack_o) // R16
        else $error("recall of defaults failed");
    chk_reset_default: assert property (disable iff (1'b0) $past(rst_i) |-> q_r.set == SET_DEFAULT
        && cycle_run_o == 3'h0 && !ack_o) // R23
        else $error("reset defaults not loaded");

endmodule
`default_nettype wire

// ---- tb/adjust_engine_model.sv ----
// Model of the analog adjustment engine behind the automatic cycles
`timescale 1ns/1ps
`default_nettype none
module adjust_engine_model #(parameter int DELAY = 30) (
    input  wire logic          clk_i,
    input  wire logic [2:0]    run_i,
    input  wire logic          fail_mode_i,
    output logic      [2:0]    done_o,
    output logic      [2:0]    fail_o,
    output logic signed [17:0] null_o
);
    int cnt = 0;
    always_ff @(posedge clk_i) begin
        cnt <= (run_i != 3'h0) ? cnt + 1 : 0;
    end
    assign null_o = 18'sh3_FF85;
    assign done_o = (cnt == DELAY && !fail_mode_i) ? run_i : 3'h0;
    assign fail_o = (cnt == DELAY && fail_mode_i) ? run_i : 3'h0;
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Register-level bench for the setting command store
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lockin_pkg::*;
    logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, ack, fmode = 0, tok;
    logic [3:0] sel = 4'hF, bsel = 4'hF;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rd, q;
    logic [2:0] rdy = 3'h7, run, done, fail;
    logic signed [17:0] nul, amt;
    int num_errors = 0, cmp_count = 0;
    logic [31:0] dflt [14] = '{32'h4, 32'h0, 32'h1_86A0, 32'h0, 32'h0, 32'h14, 32'h2, 32'h5, 32'h0, 32'h0,
                              32'h0, 32'h0, 32'h1, 32'h1};
    logic [31:0] mx [14] = '{KIND_MAX, QUAL_MAX, FREQ_MAX, TRIM_LIM, TRIM_LIM, FULL_SCALE_SENSITIVITY_MAX, RESV_MAX, TC_MAX,
                            BIT_MAX, BIT_MAX, BIT_MAX, OUTPUT_OFFSET_AMOUNT_LIM, BIT_MAX, BIT_MAX};
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    setting_command_store setting_command_store_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat),
        .dat_o(rd), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .cycle_ready_i(rdy),
        .cycle_done_i(done), .cycle_fail_i(fail), .offset_null_i(nul), .cycle_run_o(run),
        .input_filter_kind_o(), .input_filter_quality_o(), .input_filter_centre_freq_o(),
        .input_filter_freq_trim_o(), .notch_depth_trim_o(), .full_scale_sensitivity_o(),
        .dynamic_reserve_select_o(), .output_time_constant_o(), .output_rolloff_o(),
        .output_function_select_o(), .output_offset_enable_o(), .output_offset_amount_o(amt),
        .key_click_sound_enable_o(), .alarm_sound_enable_o(), .token_reply_format_o(tok));
    adjust_engine_model adjust_engine_model_inst (.clk_i(clk_i), .run_i(run), .fail_mode_i(fmode),
        .done_o(done), .fail_o(fail), .null_o(nul));
    // ---------------------------------------------------------------
    // Bus tasks
    // ---------------------------------------------------------------
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= bsel;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            results();
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (run !== 3'h0 && n < 200);
        if (n >= 200) begin
            num_errors++;
            results();
        end
    endtask
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 14; i++) rdchk("default", 8'(i * 4), dflt[i]);
        rdchk("recall last", OFS_RECALL, 32'h9);
        rdchk("unmapped", 8'h50, 32'h0);
        $display("test defaults done");
        for (int i = 0; i < 14; i++) begin
            wb(1'b1, 8'(i * 4), mx[i]);
            wb(1'b1, 8'(i * 4), mx[i] + 32'h1);
            rdchk("limit", 8'(i * 4), mx[i]);
        end
        wb(1'b1, OFS_FREQ, 32'hC7);
        rdchk("freq low", OFS_FREQ, FREQ_MAX);
        wb(1'b1, OFS_FTRIM, 32'hFFFF_FC19);
        wb(1'b1, OFS_NOTCH, 32'hFFFF_FC18);
        rdchk("trim neg", OFS_FTRIM, 32'hFFFF_FC19);
        rdchk("notch neg", OFS_NOTCH, TRIM_LIM);
        $display("test limits done");
        wb(1'b1, OFS_SAVE, 32'h3);
        wb(1'b1, OFS_RECALL, 32'h9);
        repeat (3) @(posedge clk_i);
        rdchk("recall dflt", OFS_QUAL, 32'h0);
        wb(1'b1, OFS_RECALL, 32'h3);
        repeat (3) @(posedge clk_i);
        rdchk("recall blk", OFS_QUAL, QUAL_MAX);
        rdchk("save last", OFS_SAVE, 32'h3);
        rdchk("recall blk3", OFS_RECALL, 32'h3);
        $display("test save recall done");
        wb(1'b1, OFS_OUTPUT_OFFSET_ENABLE, 32'h0);
        for (int c = 0; c < 3; c++) begin
            wb(1'b1, 8'(OFS_CYC0 + c * 4), 32'h1);
            rdchk("cyc run", 8'(OFS_CYC0 + c * 4), 32'h1);
            wb(1'b1, 8'(OFS_CYC0 + c * 4), 32'h0);
            rdchk("cyc cancel", 8'(OFS_CYC0 + c * 4), 32'h0);
            wb(1'b1, 8'(OFS_CYC0 + c * 4), 32'h1);
            wait_idle();
            rdchk("cyc done", 8'(OFS_CYC0 + c * 4), 32'h3);
            rdy[c] <= 1'b0;
            wb(1'b1, 8'(OFS_CYC0 + c * 4), 32'h1);
            rdchk("cyc cycle_cannot_start", 8'(OFS_CYC0 + c * 4), 32'h2);
            rdy[c] <= 1'b1;
        end
        chk("null port", {{14{amt[17]}}, amt}, 32'hFFFF_FF85);
        rdchk("null reg", OFS_OUTPUT_OFFSET_AMOUNT, 32'hFFFF_FF85);
        fmode <= 1'b1;
        wb(1'b1, OFS_CYC0, 32'h1);
        wait_idle();
        rdchk("cyc failed", OFS_CYC0, 32'h4);
        $display("test cycles done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("rst qual", OFS_QUAL, 32'h0);
        rdchk("rst gain", OFS_CYC0, 32'h0);
        bsel = 4'h3;
        wb(1'b1, OFS_KIND, 32'h0);
        bsel = 4'hF;
        rdchk("sel part", OFS_KIND, 32'h4);
        wb(1'b1, OFS_TOKEN, 32'h1);
        rdchk("token reg", OFS_TOKEN, 32'h1);
        chk("token port", {31'h0, tok}, 32'h1);
        $display("test reset sel token done");
        results();
    end
endmodule
`default_nettype wire
